/* File: dv/tb_vpiu_top.sv */
// self-checking bench of the interrupt unit
`timescale 1ns/1ns
module tb_vpiu_top;
	logic                 clk = 0;
	logic                 sys_rst = 1;
	logic                 reset_pin_n = 1;
	logic                 watchdog_reset = 0;
	logic                 ext0_pin = 0;
	logic                 pin_chg = 0;
	logic                 ext0_lvl = 0;
	vpiu_pkg::vpiu_src_s  periph_req = '0;
	vpiu_pkg::vpiu_src_s  src_enable = '1;
	logic                 global_enable = 1;
	logic                 core_take;
	vpiu_pkg::vpiu_core_s core_out;
	logic [10:0]          pending_out;
	logic [3:0]           lag = 0;
	logic [9:0]           taken_vec;
	int                   errors = 0;
	int                   checks_done = 0;
	// ----
	// clock, design and core
	// ----
	always #5 clk = ~clk;
	vpiu_top dut (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset),
		.ext0_pin(ext0_pin), .ext0_level_mode(ext0_lvl), .pin_change_pin(pin_chg), .periph_req(periph_req),
		.src_enable(src_enable), .global_enable(global_enable), .core_take(core_take), .core_out(core_out),
		.pending_out(pending_out));
	vpiu_core_model core (.clk(clk), .core_out(core_out), .lag(lag), .core_take(core_take), .taken_vec(taken_vec));
	task chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task pulse(input logic [10:0] b);
		@(posedge clk) periph_req <= b;
		@(posedge clk) periph_req <= '0;
	endtask
	// wait for the core to take, then compare the vector it got
	task wait_take(input logic [9:0] v);
		int n;
		n = 0;
		do begin @(posedge clk); #1; n++; end while (!core_take && n < 40);
		if (!core_take)
		begin
			errors++;
			give_verdict();
		end
		else
		begin
			@(posedge clk); #1;
			chk(taken_vec, v);
		end
	endtask
	// level mode: request zero is offered again while its pin stays high
	task s_level;
		@(posedge clk) begin ext0_lvl <= 1; ext0_pin <= 1; end
		wait_take(10'h001);
		wait_take(10'h001);
		@(posedge clk) ext0_pin <= 0;
		repeat (6) @(posedge clk); #1;
		chk(core_out.irq_valid, 0);
		chk(pending_out, 0);
		@(posedge clk) ext0_lvl <= 0;
	endtask
	// each source alone gives its own vector
	task s_vec;
		for (int i = 0; i < 11; i++)
		begin
			@(posedge clk)
			begin
				lag <= 4'(i % 4);
				if (i == 0) ext0_pin <= 1;
				else if (i == 1) pin_chg <= 1;
				else periph_req <= 11'(1) << i;
			end
			@(posedge clk) periph_req <= '0;
			wait_take(10'(i + 1));
			@(posedge clk) ext0_pin <= 0;
			repeat (3) @(posedge clk);
		end
	endtask
	// masked requests wait, then leave in address order from 004 to 00B, the disabled 003 last once enabled
	task s_prio;
		@(posedge clk) begin global_enable <= 0; src_enable <= 11'h7FB; end
		pulse(11'h7FC);
		repeat (3) @(posedge clk); #1;
		chk(pending_out, 11'h7FC);
		chk(core_out.irq_valid, 0);
		@(posedge clk) global_enable <= 1;
		for (int v = 4; v < 12; v++) wait_take(10'(v));
		chk(pending_out, 11'h004);
		@(posedge clk) src_enable <= '1;
		wait_take(10'h003);
	endtask
	// watchdog and pin reset both enter at 000, flags checked clear after the watchdog
	task s_rst;
		@(posedge clk) global_enable <= 0;
		pulse(11'h600);
		@(posedge clk) watchdog_reset <= 1;
		@(posedge clk) watchdog_reset <= 0; #1;
		chk(core_out, 12'h800);
		chk(pending_out, 0);
		@(posedge clk) reset_pin_n <= 0;
		repeat (4) @(posedge clk); #1;
		chk(core_out, 12'h800);
		@(posedge clk) reset_pin_n <= 1;
		repeat (5) @(posedge clk); #1;
		chk(core_out, 12'h000);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 0;
		s_vec();
		s_prio();
		s_level();
		s_rst();
		give_verdict();
	end
endmodule
bind vpiu_top vpiu_top_monitor mon (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
	.watchdog_reset(watchdog_reset), .ext0_pin(ext0_pin), .ext0_level_mode(ext0_level_mode),
	.pin_change_pin(pin_change_pin), .periph_req(periph_req), .src_enable(src_enable),
	.global_enable(global_enable), .core_take(core_take), .core_out(core_out), .pending_out(pending_out));

/* File: dv/vpiu_core_model.sv */
// behavioural core that accepts offered vectors after a set lag
`timescale 1ns/1ns
module vpiu_core_model
(
	input wire logic                 clk,
	input wire vpiu_pkg::vpiu_core_s core_out,
	input wire logic [3:0]           lag,
	output logic                     core_take,
	output logic [9:0]               taken_vec
);
	logic [3:0] cnt_reg = 4'h0;
	initial core_take = 1'b0;
	// wait lag cycles of offer, then take one cycle
	always @(posedge clk)
	begin
		core_take <= 1'b0;
		if (core_take)
			taken_vec <= core_out.vector;
		if (core_out.irq_valid && !core_take && cnt_reg >= lag)
			core_take <= 1'b1;
		cnt_reg <= (core_out.irq_valid && !core_take) ? cnt_reg + 4'h1 : 4'h0;
	end
endmodule

/* File: dv/vpiu_top_monitor.sv */
// checker of the interrupt unit port behaviour
`timescale 1ns/1ns
module vpiu_top_monitor
(
	input wire logic                         clk,
	input wire logic                         sys_rst,
	input wire logic                         reset_pin_n,
	input wire logic                         watchdog_reset,
	input wire logic                         ext0_pin,
	input wire logic                         ext0_level_mode,
	input wire logic                         pin_change_pin,
	input wire vpiu_pkg::vpiu_src_s          periph_req,
	input wire vpiu_pkg::vpiu_src_s          src_enable,
	input wire logic                         global_enable,
	input wire logic                         core_take,
	input wire vpiu_pkg::vpiu_core_s         core_out,
	input wire logic [vpiu_pkg::NUM_SRC-1:0] pending_out
);
	// ----
	// properties
	// ----
	wire [10:0] en_bits = src_enable;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// offered vector lies in the interrupt rows of the table
	property p_vec_range;
		core_out.irq_valid |-> core_out.vector inside {[10'h001:10'h00B]};
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector out of table");
	property p_rst_vec;
		core_out.reset_entry |-> core_out.vector == 10'h000 && !core_out.irq_valid;
	endproperty
	a_rst_vec: assert property (p_rst_vec) else $error("reset entry wrong");
	property p_wdog;
		watchdog_reset |=> core_out.reset_entry && pending_out == '0;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog missed");
	property p_mask;
		!global_enable |=> !core_out.irq_valid;
	endproperty
	a_mask: assert property (p_mask) else $error("offer while globally masked");
	property p_src_ok;
		core_out.irq_valid |-> (($past(en_bits) >> (core_out.vector - 10'h001)) & 11'h001) != 11'h000;
	endproperty
	a_src_ok: assert property (p_src_ok) else $error("offer of disabled source");
	// pending flags of peripheral sources only clear on a take or a reset
	property p_hold;
		disable iff (sys_rst || !reset_pin_n)
		!core_take && !watchdog_reset && !core_out.reset_entry
		|=> (pending_out[10:2] & $past(pending_out[10:2])) == $past(pending_out[10:2]);
	endproperty
	a_hold: assert property (p_hold) else $error("pending flag lost");
	property p_take;
		core_out.irq_valid && core_take |=> !core_out.irq_valid [*2];
	endproperty
	a_take: assert property (p_take) else $error("offer after take");
	sequence s_ta_req;
		periph_req == 11'h020 && en_bits[5] && global_enable && pending_out == '0
		&& !core_out.irq_valid && !core_out.reset_entry && !watchdog_reset;
	endsequence
	sequence s_ta_offer;
		pending_out[5] ##1 core_out.irq_valid && core_out.vector == 10'h006;
	endsequence
	property p_walk;
		s_ta_req |=> s_ta_offer;
	endproperty
	a_walk: assert property (p_walk) else $error("timer a overflow offer wrong");
endmodule

/* File: logic/vpiu_pkg.sv */
// constants and carrier types of the vectored priority interrupt unit
package vpiu_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NUM_SRC = 11;
	localparam int VEC_W   = 10;
	localparam int IDX_W   = 4;

	// ------------------------------------------------------------
	// program-memory vector addresses, one word each
	// ------------------------------------------------------------
	localparam logic [VEC_W-1:0] VEC_RESET     = 10'h000;
	localparam logic [VEC_W-1:0] VEC_EXT0      = 10'h001;
	localparam logic [VEC_W-1:0] VEC_PIN_CHG   = 10'h002;
	localparam logic [VEC_W-1:0] VEC_TB_CMP_A  = 10'h003;
	localparam logic [VEC_W-1:0] VEC_TB_CMP_B  = 10'h004;
	localparam logic [VEC_W-1:0] VEC_TB_OVF    = 10'h005;
	localparam logic [VEC_W-1:0] VEC_TA_OVF    = 10'h006;
	localparam logic [VEC_W-1:0] VEC_SER_START = 10'h007;
	localparam logic [VEC_W-1:0] VEC_SER_OVF   = 10'h008;
	localparam logic [VEC_W-1:0] VEC_NVM_RDY   = 10'h009;
	localparam logic [VEC_W-1:0] VEC_COMP      = 10'h00A;
	localparam logic [VEC_W-1:0] VEC_CONV_DONE = 10'h00B;

	// ------------------------------------------------------------
	// source index 0 is the highest priority interrupt source
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_EXT0      = 4'h0;
	localparam logic [IDX_W-1:0] IDX_CONV_DONE = 4'hA;

	// reset values
	localparam logic [NUM_SRC-1:0] PEND_RST = 11'h000;

	// state machine, gray along idle -> offer -> taken
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'h0,
		ST_OFFER = 2'h1,
		ST_TAKEN = 2'h3,
		ST_RESET = 2'h2
	} vpiu_state_e;

	// one bit per source, msb first is lowest priority
	typedef struct packed
	{
		logic conv_done_req;
		logic comparator_req;
		logic nvm_ready_req;
		logic serial_overflow_req;
		logic serial_start_req;
		logic timer_a_overflow_req;
		logic timer_b_overflow_req;
		logic timer_b_compare_b_req;
		logic timer_b_compare_a_req;
		logic pin_change_req;
		logic external_request_zero;
	} vpiu_src_s;

	// answer towards the core
	typedef struct packed
	{
		logic             reset_entry;
		logic             irq_valid;
		logic [VEC_W-1:0] vector;
	} vpiu_core_s;

endpackage

/* File: logic/vpiu_prio_enc.sv */
// fixed priority encoder, lowest index wins
`timescale 1ns/1ns

module vpiu_prio_enc
#(
	parameter int N = vpiu_pkg::NUM_SRC,
	parameter int W = vpiu_pkg::IDX_W
)
(
	input  wire logic [N-1:0] req,
	output logic              found,
	output logic [W-1:0]      index
);

	// ------------------------------------------------------------
	// scan from the lowest priority upward so index 0 wins last
	// ------------------------------------------------------------
	always_comb
	begin
		found = 1'b0;
		index = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				found = 1'b1;
				index = W'(i);
			end
		end
	end

endmodule

/* File: logic/vpiu_top.sv */
// vectored priority interrupt unit: pending flags, masking, priority, vector output
`timescale 1ns/1ns

// Functional notes
// RULE_01 - eleven interrupt sources plus reset, each with its own vector
// RULE_02 - a source is taken only with its enable and global enable set
// RULE_03 - vectors occupy the lowest program words, one word each
// RULE_04 - among enabled pending requests the lowest vector address is served first
// RULE_05 - reset ranks highest, external request zero next, then the others
// RULE_06 - reset pin and watchdog reset both start at address 000
// RULE_07 - external request zero vectors to address 001
// RULE_08 - pin change request vectors to address 002
// RULE_09 - second timer compare a 003, compare b 004, overflow 005
// RULE_10 - first timer overflow vectors to address 006
// RULE_11 - serial start vectors to 007, serial overflow to 008
// RULE_12 - nonvolatile memory ready vectors to address 009
// RULE_13 - comparator request vectors to address 00A
// RULE_14 - conversion complete vectors to 00B, lowest priority
// RULE_15 - a masked pending request stays pending until enabled
module vpiu_top
(
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         reset_pin_n,
	input  wire logic                         watchdog_reset,
	input  wire logic                         ext0_pin,
	input  wire logic                         ext0_level_mode,
	input  wire logic                         pin_change_pin,
	input  wire vpiu_pkg::vpiu_src_s          periph_req,
	input  wire vpiu_pkg::vpiu_src_s          src_enable,
	input  wire logic                         global_enable,
	input  wire logic                         core_take,
	output vpiu_pkg::vpiu_core_s              core_out,
	output logic [vpiu_pkg::NUM_SRC-1:0]      pending_out
);

	// ------------------------------------------------------------
	// vector address of a source index
	// ------------------------------------------------------------
	function automatic logic [vpiu_pkg::VEC_W-1:0] vec_of
	(
		input logic [vpiu_pkg::IDX_W-1:0] idx
	);
		// one consecutive word above the reset word per source
		vec_of = vpiu_pkg::VEC_EXT0 + vpiu_pkg::VEC_W'(idx); // [RULE_03] [RULE_07] [RULE_14]
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] sync1_reg;
	logic [2:0] sync1_next;
	logic [2:0] sync2_reg;
	logic [2:0] sync2_next;
	logic       ext0_prev_reg;
	logic       ext0_prev_next;
	logic       pchg_prev_reg;
	logic       pchg_prev_next;

	// first stage feeds only the second stage
	always_comb
	begin
		sync1_next     = {reset_pin_n, ext0_pin, pin_change_pin};
		sync2_next     = sync1_reg;
		ext0_prev_next = sync2_reg[1];
		pchg_prev_next = sync2_reg[0];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1_reg     <= 3'h4;
			sync2_reg     <= 3'h4;
			ext0_prev_reg <= 1'b0;
			pchg_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg     <= sync1_next;
			sync2_reg     <= sync2_next;
			ext0_prev_reg <= ext0_prev_next;
			pchg_prev_reg <= pchg_prev_next;
		end
	end

	// ------------------------------------------------------------
	// request events
	// ------------------------------------------------------------
	logic                          pin_rst_n_s;
	logic                          ext0_s;
	logic                          reset_event;
	logic                          ext0_edge;
	logic                          pchg_edge;
	logic [vpiu_pkg::NUM_SRC-1:0]  set_vec;
	logic [vpiu_pkg::NUM_SRC-1:0]  enable_vec;

	// reset pin low or watchdog both mean a reset entry
	assign pin_rst_n_s = sync2_reg[2];
	assign ext0_s      = sync2_reg[1];
	assign reset_event = ~pin_rst_n_s | watchdog_reset; // [RULE_06]
	assign ext0_edge   = ext0_s & ~ext0_prev_reg;
	assign pchg_edge   = sync2_reg[0] ^ pchg_prev_reg;

	// peripheral pulses plus pin events, one bit per source
	always_comb
	begin
		set_vec = periph_req; // [RULE_01]
		set_vec[vpiu_pkg::IDX_EXT0] = ext0_edge;
		set_vec[vpiu_pkg::IDX_EXT0 + 4'h1] = pchg_edge;
	end

	// individual enable and global enable together
	assign enable_vec = src_enable & {vpiu_pkg::NUM_SRC{global_enable}}; // [RULE_02]

	// ------------------------------------------------------------
	// pending flags
	// ------------------------------------------------------------
	logic [vpiu_pkg::NUM_SRC-1:0]  pend_reg;
	logic [vpiu_pkg::NUM_SRC-1:0]  pend_next;
	logic [vpiu_pkg::NUM_SRC-1:0]  clr_vec;
	logic [vpiu_pkg::NUM_SRC-1:0]  pend_eff;
	logic [vpiu_pkg::NUM_SRC-1:0]  cand;
	logic                          cand_found;
	logic [vpiu_pkg::IDX_W-1:0]    cand_idx;
	logic [vpiu_pkg::IDX_W-1:0]    sel_reg;
	logic [vpiu_pkg::IDX_W-1:0]    sel_next;
	vpiu_pkg::vpiu_state_e         state_reg;
	vpiu_pkg::vpiu_state_e         state_next;

	// taken source is cleared, a new event in that cycle wins
	always_comb
	begin
		clr_vec = '0;
		if (state_reg == vpiu_pkg::ST_OFFER && core_take)
		begin
			clr_vec[sel_reg] = 1'b1;
		end
		pend_next = (pend_reg & ~clr_vec) | set_vec; // [RULE_15]
		if (reset_event)
		begin
			pend_next = vpiu_pkg::PEND_RST;
		end
	end

	// level mode: external request zero is seen only while the pin is high
	always_comb
	begin
		pend_eff = pend_reg;
		if (ext0_level_mode)
		begin
			pend_eff[vpiu_pkg::IDX_EXT0] = ext0_s;
		end
	end

	// masked requests stay in pend_reg and are merely not offered
	assign cand = pend_eff & enable_vec; // [RULE_02] [RULE_15]

	// lowest index is lowest vector address, served first
	vpiu_prio_enc
	#(
		.N (vpiu_pkg::NUM_SRC),
		.W (vpiu_pkg::IDX_W)
	)
	u_prio
	(
		.req   (cand),
		.found (cand_found),
		.index (cand_idx)
	); // [RULE_04] [RULE_05]

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pend_reg <= vpiu_pkg::PEND_RST;
		end
		else
		begin
			pend_reg <= pend_next;
		end
	end

	// ------------------------------------------------------------
	// offer state machine and core answer
	// ------------------------------------------------------------
	vpiu_pkg::vpiu_core_s core_next;

	// reset overrides everything, then the best pending source is offered
	always_comb
	begin
		state_next = state_reg;
		sel_next   = sel_reg;
		core_next  = core_out;
		case (state_reg)
			vpiu_pkg::ST_IDLE:
			begin
				core_next.reset_entry = 1'b0;
				if (cand_found)
				begin
					state_next          = vpiu_pkg::ST_OFFER;
					sel_next            = cand_idx;
					core_next.irq_valid = 1'b1;
					core_next.vector    = vec_of(cand_idx); // [RULE_07] [RULE_08] [RULE_09]
				end
			end
			vpiu_pkg::ST_OFFER:
			begin
				if (core_take)
				begin
					state_next          = vpiu_pkg::ST_TAKEN;
					core_next.irq_valid = 1'b0;
				end
				else if (!cand_found)
				begin
					state_next          = vpiu_pkg::ST_IDLE;
					core_next.irq_valid = 1'b0;
				end
				else
				begin
					sel_next         = cand_idx; // [RULE_04]
					core_next.vector = vec_of(cand_idx); // [RULE_10] [RULE_11] [RULE_12] [RULE_13]
				end
			end
			vpiu_pkg::ST_TAKEN:
			begin
				state_next = vpiu_pkg::ST_IDLE;
			end
			vpiu_pkg::ST_RESET:
			begin
				if (!reset_event)
				begin
					state_next            = vpiu_pkg::ST_IDLE;
					core_next.reset_entry = 1'b0;
				end
			end
			default:
			begin
				state_next = vpiu_pkg::ST_IDLE;
			end
		endcase
		if (reset_event)
		begin
			state_next            = vpiu_pkg::ST_RESET; // [RULE_05]
			sel_next              = vpiu_pkg::IDX_EXT0;
			core_next.reset_entry = 1'b1;
			core_next.irq_valid   = 1'b0;
			core_next.vector      = vpiu_pkg::VEC_RESET; // [RULE_06]
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_reg   <= vpiu_pkg::ST_IDLE;
			sel_reg     <= vpiu_pkg::IDX_EXT0;
			core_out    <= '{reset_entry: 1'b0, irq_valid: 1'b0, vector: vpiu_pkg::VEC_RESET};
			pending_out <= vpiu_pkg::PEND_RST;
		end
		else
		begin
			state_reg   <= state_next;
			sel_reg     <= sel_next;
			core_out    <= core_next;
			pending_out <= pend_next;
		end
	end

endmodule
